// >>> rtl/adc_power_mode_control.sv
// Purpose: Power, wait, stop, freeze and reset control of the converter, APB side.
// Assumes: stop_req, wait_req, debug and port pins come from outside pclk.
// Notes: Each APB access answers with pready in the first access cycle.
`timescale 1ns/1ns
module adc_power_mode_control (
  input wire logic pclk,
  input wire logic presetn,
  input adc_ctrl_pkg::apb_req_t apb_req,
  output adc_ctrl_pkg::apb_rsp_t apb_rsp,
  input wire logic stop_req,
  input wire logic wait_req,
  input wire logic background_debug_active,
  input wire logic [7:0] analog_pin_input_port,
  input wire logic [adc_ctrl_pkg::RESULT_W-1:0] conv_data,
  output logic analog_bias_en,
  output logic digital_clk_en,
  output logic sample_clk_en,
  output logic convert_clk_en,
  output adc_ctrl_pkg::mode_t mode
);
  import adc_ctrl_pkg::*;

  typedef struct packed {
    apb_rsp_t rsp;
    logic power_up;
    logic wait_halt_en;
    logic [1:0] frz_sel;
    logic [SEQ_CFG_W-1:0] seq_cfg;
    logic [NUM_CH-1:0] ccf;
    logic scf;
    logic [NUM_CH-1:0][RESULT_W-1:0] result;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [7:0] port1;
    logic [7:0] port2;
    logic bias_en;
    logic dig_en;
    mode_t mode;
  } ctrl_state_t;

  ctrl_state_t s_reg;
  ctrl_state_t s_next;
  seq_ctl_t seq_ctl;
  seq_stat_t seq_stat;

  // Synchronised pin levels, taken from the second stage only
  logic stop_s;
  logic wait_s;
  logic bdm_s;
  assign stop_s = s_reg.sync2[0];
  assign wait_s = s_reg.sync2[1];
  assign bdm_s = s_reg.sync2[2];

  // Power-down causes
  logic prog_pd;
  logic wait_pd;
  logic any_pd;
  assign prog_pd = !s_reg.power_up || stop_s;
  assign wait_pd = wait_s && s_reg.wait_halt_en;
  assign any_pd = prog_pd || wait_pd;

  // Bus phases
  logic setup_ph;
  logic access_done;
  logic wr_done;
  assign setup_ph = apb_req.psel && !apb_req.penable && !s_reg.rsp.pready;
  assign access_done = apb_req.psel && apb_req.penable && s_reg.rsp.pready;
  assign wr_done = access_done && apb_req.pwrite && !s_reg.rsp.pslverr;

  // True when a finished write hits the given offset
  function automatic logic wr_hit(input logic done, input logic [7:0] addr,
                                  input logic [7:0] ofs);
    wr_hit = done && (addr == ofs);
  endfunction : wr_hit

  // Known offsets
  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == OFS_CTRL_TWO) || (addr == OFS_CTRL_THREE) ||
                (addr == OFS_SEQ_START) || (addr == OFS_TEST) ||
                (addr == OFS_STATUS) || (addr == OFS_PORT) ||
                ((addr >= OFS_RESULT) && (addr <= OFS_RESULT_END) &&
                 (addr[1:0] == 2'b00));
  endfunction : is_mapped

  logic soft_rst;
  logic seq_wr;
  assign soft_rst = wr_hit(wr_done, apb_req.paddr, OFS_TEST) &&
                    apb_req.pwdata[BIT_SOFT_RESET];
  assign seq_wr = wr_hit(wr_done, apb_req.paddr, OFS_SEQ_START);

  // Sequencer steering: program and stop power down abort, wait only holds
  always_comb begin
    seq_ctl.cfg = seq_wr ? apb_req.pwdata[SEQ_CFG_W-1:0] : s_reg.seq_cfg;
    seq_ctl.abort = prog_pd || soft_rst;
    seq_ctl.start = seq_wr && !prog_pd;
    seq_ctl.hold_now = wait_pd || (bdm_s && s_reg.frz_sel == FRZ_IMMEDIATE);
    seq_ctl.hold_boundary = bdm_s && (s_reg.frz_sel == FRZ_AT_BOUNDARY);
  end

  conversion_sequencer u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .ctl(seq_ctl),
    .stat(seq_stat)
  );

  // Result slot addressed by the bus
  logic [2:0] res_sel;
  assign res_sel = apb_req.paddr[4:2];

  // Read value of the addressed register
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    if (apb_req.paddr == OFS_CTRL_TWO) begin
      rd_val[BIT_POWER_UP] = s_reg.power_up;
      rd_val[BIT_WAIT_HALT] = s_reg.wait_halt_en;
    end else if (apb_req.paddr == OFS_CTRL_THREE) begin
      rd_val[1:0] = s_reg.frz_sel;
    end else if (apb_req.paddr == OFS_SEQ_START) begin
      rd_val[SEQ_CFG_W-1:0] = s_reg.seq_cfg;
    end else if (apb_req.paddr == OFS_STATUS) begin
      rd_val[NUM_CH-1:0] = s_reg.ccf;
      rd_val[BIT_SCF] = s_reg.scf;
      rd_val[POS_MODE+1:POS_MODE] = s_reg.mode;
    end else if (apb_req.paddr == OFS_PORT) begin
      rd_val[7:0] = s_reg.port2;
    end else if (apb_req.paddr >= OFS_RESULT) begin
      rd_val[RESULT_W-1:0] = s_reg.result[res_sel];
    end
  end

  // Next state of the whole control block
  always_comb begin
    s_next = s_reg;

    // Two-stage pin synchronisers
    s_next.sync1 = {background_debug_active, wait_req, stop_req};
    s_next.sync2 = s_reg.sync1;
    s_next.port1 = analog_pin_input_port;
    s_next.port2 = s_reg.port1;

    // Bus answer prepared in the setup cycle, released after the access
    if (setup_ph) begin
      s_next.rsp.pready = 1'b1;
      if (wait_pd) begin
        // Whole register file is shut off during wait power down
        s_next.rsp.pslverr = 1'b1;
        s_next.rsp.prdata = 32'h0000_0000;
      end else begin
        // Program and stop power down, idle, run and freeze all keep full access
        s_next.rsp.pslverr = !is_mapped(apb_req.paddr);
        // Unmapped words read zero, not a result slot that aliases them
        s_next.rsp.prdata = (apb_req.pwrite || !is_mapped(apb_req.paddr)) ? 32'h0000_0000 : rd_val;
      end
    end else if (access_done) begin
      s_next.rsp.pready = 1'b0;
      s_next.rsp.pslverr = 1'b0;
    end

    // Control writes; power-up only changes the bit, nothing else
    if (wr_hit(wr_done, apb_req.paddr, OFS_CTRL_TWO)) begin
      s_next.power_up = apb_req.pwdata[BIT_POWER_UP];
      s_next.wait_halt_en = apb_req.pwdata[BIT_WAIT_HALT];
    end
    if (wr_hit(wr_done, apb_req.paddr, OFS_CTRL_THREE)) begin
      s_next.frz_sel = apb_req.pwdata[1:0];
    end
    if (seq_wr) begin
      s_next.seq_cfg = apb_req.pwdata[SEQ_CFG_W-1:0];
    end

    // Status flags: write one to clear, a finishing conversion wins
    if (wr_hit(wr_done, apb_req.paddr, OFS_STATUS)) begin
      s_next.ccf = s_reg.ccf & ~apb_req.pwdata[NUM_CH-1:0];
      s_next.scf = s_reg.scf && !apb_req.pwdata[BIT_SCF];
    end
    if (seq_wr) begin
      s_next.ccf = '0;
      s_next.scf = 1'b0;
    end
    if (seq_stat.res_valid) begin
      s_next.ccf[seq_stat.res_idx] = 1'b1;
      s_next.result[seq_stat.res_idx] = conv_data;
    end
    if (seq_stat.seq_done) begin
      s_next.scf = 1'b1;
    end

    // Soft module reset: initialise control, test and status, keep power-up
    if (soft_rst) begin
      s_next.wait_halt_en = 1'b0;
      s_next.frz_sel = FRZ_RESET;
      s_next.seq_cfg = SEQ_CFG_RESET;
      s_next.ccf = '0;
      s_next.scf = 1'b0;
      s_next.power_up = s_reg.power_up;
    end

    // Analog bias follows the power-down decision; digital clocks also stop on an immediate freeze
    s_next.bias_en = !any_pd;
    s_next.dig_en = !any_pd && !seq_ctl.hold_now;

    // Reported mode; a freeze shows frozen while debug is active, even after the sequence drained
    if (any_pd) begin
      s_next.mode = MODE_DOWN;
    end else if (bdm_s && s_reg.frz_sel[1]) begin
      s_next.mode = MODE_FROZEN;
    end else if (seq_stat.busy || seq_ctl.start) begin
      // A start shows run at once, so stage clocks never run under idle
      s_next.mode = MODE_RUN;
    end else begin
      s_next.mode = MODE_IDLE;
    end
  end

  // State register; power-up clears so the block starts powered down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flip-flops
  assign apb_rsp = s_reg.rsp;
  assign analog_bias_en = s_reg.bias_en;
  assign digital_clk_en = s_reg.dig_en;
  assign sample_clk_en = seq_stat.sample_clk_en;
  assign convert_clk_en = seq_stat.convert_clk_en;
  assign mode = s_reg.mode;

endmodule : adc_power_mode_control

// >>> rtl/adc_ctrl_pkg.sv
// Purpose: Shared constants and types for the converter power and mode control.
// Assumes: APB slave on pclk at 250 MHz, one aligned 32-bit word per register.
// Notes: Rules of the block follow, one to a line.
package adc_ctrl_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_TWO = 8'h00;
  localparam logic [7:0] OFS_CTRL_THREE = 8'h04;
  localparam logic [7:0] OFS_SEQ_START = 8'h08;
  localparam logic [7:0] OFS_TEST = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_PORT = 8'h14;
  localparam logic [7:0] OFS_RESULT = 8'h20;
  localparam logic [7:0] OFS_RESULT_END = 8'h3C;

  // Field positions
  localparam int BIT_POWER_UP = 0;
  localparam int BIT_WAIT_HALT = 1;
  localparam int BIT_SOFT_RESET = 0;
  localparam int BIT_SCF = 8;
  localparam int POS_MODE = 9;
  localparam int SEQ_CFG_W = 6;
  localparam int RESULT_W = 10;
  localparam int NUM_CH = 8;

  // Reset values
  localparam logic [1:0] FRZ_RESET = 2'h0;
  localparam logic [SEQ_CFG_W-1:0] SEQ_CFG_RESET = 6'h00;

  // Freeze responses
  localparam logic [1:0] FRZ_AT_BOUNDARY = 2'h2;
  localparam logic [1:0] FRZ_IMMEDIATE = 2'h3;

  // Converter timing in module clocks
  localparam logic [4:0] SAMPLE_CYCLES = 5'h08;
  localparam logic [4:0] CONVERT_CYCLES = 5'h0C;

  typedef enum logic [1:0] {
    MODE_DOWN = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_RUN = 2'b10,
    MODE_FROZEN = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_SAMPLE = 2'b01,
    PH_CONVERT = 2'b10,
    PH_GAP = 2'b11
  } phase_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  // Sequence config: [2:0] unused, sequences always start at slot 0, [4:3] length code, [5] continuous
  typedef struct packed {
    logic start;
    logic abort;
    logic hold_now;
    logic hold_boundary;
    logic [SEQ_CFG_W-1:0] cfg;
  } seq_ctl_t;

  typedef struct packed {
    logic busy;
    logic res_valid;
    logic [2:0] res_idx;
    logic seq_done;
    logic sample_clk_en;
    logic convert_clk_en;
  } seq_stat_t;

endpackage : adc_ctrl_pkg

// >>> rtl/conversion_sequencer.sv
// Purpose: Steps sample and convert phases through a conversion sequence.
// Assumes: Controls arrive on pclk; hold freezes the timing position.
// Notes: Clock enables are registered so the stage gates stay glitch free.
`timescale 1ns/1ns
module conversion_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input adc_ctrl_pkg::seq_ctl_t ctl,
  output adc_ctrl_pkg::seq_stat_t stat
);
  import adc_ctrl_pkg::*;

  typedef struct packed {
    phase_t phase;
    logic [4:0] cnt;
    logic [2:0] idx;
    seq_stat_t stat;
  } seq_state_t;

  seq_state_t s_reg;
  seq_state_t s_next;

  // Index of the last conversion for a length code
  function automatic logic [2:0] last_idx(input logic [1:0] code);
    last_idx = code[1] ? 3'h7 : (code[0] ? 3'h3 : 3'h0);
  endfunction : last_idx

  // Next state of the sequence walker
  always_comb begin
    s_next = s_reg;
    s_next.stat.res_valid = 1'b0;
    s_next.stat.seq_done = 1'b0;
    if (ctl.abort) begin
      s_next.phase = PH_IDLE;
    end else if (ctl.start) begin
      s_next.phase = PH_SAMPLE;
      s_next.cnt = 5'h00;
      s_next.idx = 3'h0;
    end else if (!ctl.hold_now) begin
      case (s_reg.phase)
        PH_SAMPLE: begin
          s_next.cnt = s_reg.cnt + 5'h01;
          if (s_reg.cnt == SAMPLE_CYCLES - 5'h01) begin
            s_next.phase = PH_CONVERT;
            s_next.cnt = 5'h00;
          end
        end
        PH_CONVERT: begin
          s_next.cnt = s_reg.cnt + 5'h01;
          if (s_reg.cnt == CONVERT_CYCLES - 5'h01) begin
            s_next.stat.res_valid = 1'b1;
            s_next.stat.res_idx = s_reg.idx;
            s_next.cnt = 5'h00;
            s_next.phase = PH_GAP;
            s_next.idx = s_reg.idx + 3'h1;
            if (s_reg.idx == last_idx(ctl.cfg[4:3])) begin
              s_next.stat.seq_done = 1'b1;
              s_next.idx = 3'h0;
              if (!ctl.cfg[5]) begin
                s_next.phase = PH_IDLE;
              end
            end
          end
        end
        PH_GAP: begin
          // Boundary freeze waits here, before the next sample period
          if (!ctl.hold_boundary) begin
            s_next.phase = PH_SAMPLE;
          end
        end
        default: begin
          s_next.phase = PH_IDLE;
        end
      endcase
    end
    s_next.stat.busy = (s_next.phase != PH_IDLE);
    s_next.stat.sample_clk_en = (s_next.phase == PH_SAMPLE) && !ctl.hold_now;
    s_next.stat.convert_clk_en = (s_next.phase == PH_CONVERT) && !ctl.hold_now;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign stat = s_reg.stat;

endmodule : conversion_sequencer

// >>> bench/adc_power_mode_chk.sv
// Purpose: Port-level assertions for the converter power and mode control.
// Assumes: One pclk domain, presetn async active low.
// Notes: Pin inputs pass a 2-FF sync, so stop needs 3 samples to show.
`timescale 1ns/1ns
module adc_power_mode_chk (
  input wire logic pclk,
  input wire logic presetn,
  input adc_ctrl_pkg::apb_req_t apb_req,
  input adc_ctrl_pkg::apb_rsp_t apb_rsp,
  input wire logic stop_req,
  input wire logic analog_bias_en,
  input wire logic digital_clk_en,
  input wire logic sample_clk_en,
  input wire logic convert_clk_en,
  input adc_ctrl_pkg::mode_t mode
);
  import adc_ctrl_pkg::*;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Leaving reset must land in power down
  reset_down_a: assert property ($rose(presetn) |-> mode == MODE_DOWN && !analog_bias_en)
    else $error("not powered down after reset");
  // Setup cycle is answered in the first access cycle
  ready_setup_a: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("pready missing in access cycle");
  ready_access_a: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
    else $error("pready outside access phase");
  ready_once_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready held past completion");
  // Sample and convert stages never clock together
  stage_excl_a: assert property (!(sample_clk_en && convert_clk_en))
    else $error("both stage clocks enabled");
  // Stages gate their clocks when nothing runs; two cycles allow for skew
  idle_gate_a: assert property ((mode inside {MODE_DOWN, MODE_IDLE})[*2]
    |-> !sample_clk_en && !convert_clk_en)
    else $error("stage clock running while inactive");
  run_power_a: assert property (mode == MODE_RUN |-> analog_bias_en && digital_clk_en)
    else $error("run without power");
  down_power_a: assert property (mode == MODE_DOWN |-> !analog_bias_en && !digital_clk_en)
    else $error("power down leaves power on");
  stop_down_a: assert property (stop_req[*3] |=> mode == MODE_DOWN)
    else $error("stop did not power down");

  // Main scenarios reached
  run_c: cover property (mode == MODE_RUN);
  frozen_c: cover property (mode == MODE_FROZEN);
  refuse_c: cover property (apb_rsp.pready && apb_rsp.pslverr);
endmodule : adc_power_mode_chk

bind adc_power_mode_control adc_power_mode_chk chk_u (.pclk, .presetn, .apb_req, .apb_rsp,
  .stop_req, .analog_bias_en, .digital_clk_en, .sample_clk_en, .convert_clk_en, .mode);

// >>> bench/adc_power_mode_control_bench.sv
// Purpose: Self-checking bench for the converter power and mode control.
// Assumes: APB answers in the first access cycle; pins settle 3 edges on.
// Notes: Register table first, then power, wait, freeze and reset cases.
`timescale 1ns/1ns
module adc_power_mode_control_bench;
  import adc_ctrl_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;
  logic pclk, presetn, stop_req, wait_req, background_debug_active;
  logic analog_bias_en, digital_clk_en, sample_clk_en, convert_clk_en;
  logic [7:0] analog_pin_input_port;
  logic [RESULT_W-1:0] conv_data;
  apb_req_t req;
  apb_rsp_t rsp;
  mode_t mode;
  logic [31:0] q;
  logic e;
  int failures, checked;
  row_t rows[9];
  logic [1:0] sel[3] = '{2'h0, FRZ_AT_BOUNDARY, FRZ_IMMEDIATE};
  // Bias settling allowance kept by software; the block does not enforce it
  localparam int BIAS_SETTLE = 16;

  adc_power_mode_control dut_u (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .stop_req(stop_req), .wait_req(wait_req), .background_debug_active(background_debug_active),
    .analog_pin_input_port(analog_pin_input_port), .conv_data(conv_data),
    .analog_bias_en(analog_bias_en), .digital_clk_en(digital_clk_en),
    .sample_clk_en(sample_clk_en), .convert_clk_en(convert_clk_en), .mode(mode));

  // 250 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; request held until pready is sampled high
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    q = rsp.prdata;
    e = rsp.pslverr;
    chk(32'(n < 20), 32'h1);
    req <= '0;
  endtask : acc

  // Bounded wait for a mode, then compare it
  task automatic waitm(input mode_t m);
    int n;
    n = 0;
    while (mode !== m && n < 60) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(mode), 32'(m));
  endtask : waitm

  task automatic finish_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  // Watchdog: the whole run needs under 2000 cycles
  initial begin
    #40000;
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    rows[0] = '{1'b0, OFS_CTRL_TWO, 32'h0, 32'h0, 1'b0};
    rows[1] = '{1'b1, OFS_CTRL_THREE, 32'h2, 32'h0, 1'b0};
    rows[2] = '{1'b0, OFS_CTRL_THREE, 32'h0, 32'h2, 1'b0};
    rows[3] = '{1'b0, OFS_RESULT, 32'h0, 32'h0, 1'b0};
    rows[4] = '{1'b0, OFS_TEST, 32'h0, 32'h0, 1'b0};
    rows[5] = '{1'b0, 8'h18, 32'h0, 32'h0, 1'b1};
    rows[6] = '{1'b1, OFS_CTRL_TWO, 32'h1, 32'h0, 1'b0};
    rows[7] = '{1'b0, OFS_CTRL_THREE, 32'h0, 32'h2, 1'b0};
    rows[8] = '{1'b0, OFS_PORT, 32'h0, 32'hA5, 1'b0};
    presetn = 1'b0;
    req = '0;
    {stop_req, wait_req, background_debug_active} = 3'h0;
    analog_pin_input_port = 8'hA5;
    conv_data = 10'h2A5;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk(32'(mode), 32'(MODE_DOWN));
    foreach (rows[i]) begin
      acc(rows[i].w, rows[i].a, rows[i].d);
      chk(q, rows[i].x);
      chk(32'(e), 32'(rows[i].e));
    end
    // Bias must settle after power up before the first conversion
    repeat (BIAS_SETTLE) @(posedge pclk);
    // Single conversion, port read mid-run
    acc(1'b1, OFS_SEQ_START, 32'h0);
    acc(1'b0, OFS_PORT, 32'h0);
    chk(q, 32'hA5);
    chk(32'(mode), 32'(MODE_RUN));
    waitm(MODE_IDLE);
    acc(1'b0, OFS_STATUS, 32'h0);
    chk(q & 32'h1FF, 32'h101);
    acc(1'b0, OFS_RESULT, 32'h0);
    chk(q, 32'h2A5);
    // Unmapped word above the results is refused and reads zero
    acc(1'b0, 8'h40, 32'h0);
    chk({q[30:0], e}, 32'h1);
    // Four-conversion sequence fills slots 0 to 3, then stops
    acc(1'b1, OFS_SEQ_START, 32'h08);
    repeat (90) @(posedge pclk);
    acc(1'b0, OFS_STATUS, 32'h0);
    chk(q & 32'h1FF, 32'h10F);
    acc(1'b0, OFS_RESULT + 8'h0C, 32'h0);
    chk(q, 32'h2A5);
    chk(32'(mode), 32'(MODE_IDLE));
    // Continuous run, then restart clears flags only
    acc(1'b1, OFS_SEQ_START, 32'h20);
    repeat (30) @(posedge pclk);
    acc(1'b1, OFS_SEQ_START, 32'h20);
    acc(1'b0, OFS_STATUS, 32'h0);
    chk(q & 32'h1FF, 32'h0);
    acc(1'b0, OFS_CTRL_THREE, 32'h0);
    chk(q, 32'h2);
    // Program power down aborts; power up returns to idle
    acc(1'b1, OFS_CTRL_TWO, 32'h0);
    waitm(MODE_DOWN);
    chk(32'({analog_bias_en, digital_clk_en}), 32'h0);
    acc(1'b1, OFS_CTRL_TWO, 32'h1);
    waitm(MODE_IDLE);
    repeat (30) @(posedge pclk);
    chk(32'(mode), 32'(MODE_IDLE));
    chk(32'({analog_bias_en, digital_clk_en}), 32'h3);
    // Stop powers down for its duration
    stop_req <= 1'b1;
    waitm(MODE_DOWN);
    stop_req <= 1'b0;
    waitm(MODE_IDLE);
    // Wait ignored with halt clear, honoured with it set
    wait_req <= 1'b1;
    repeat (5) @(posedge pclk);
    acc(1'b0, OFS_CTRL_TWO, 32'h0);
    chk({q[30:0], e}, 32'h2);
    chk(32'(mode), 32'(MODE_IDLE));
    wait_req <= 1'b0;
    acc(1'b1, OFS_CTRL_TWO, 32'h3);
    acc(1'b1, OFS_SEQ_START, 32'h20);
    wait_req <= 1'b1;
    waitm(MODE_DOWN);
    acc(1'b0, OFS_CTRL_TWO, 32'h0);
    chk({q[30:0], e}, 32'h1);
    wait_req <= 1'b0;
    waitm(MODE_RUN);
    // Each freeze response with the sequence running
    foreach (sel[i]) begin
      acc(1'b1, OFS_CTRL_THREE, 32'(sel[i]));
      background_debug_active <= 1'b1;
      repeat (30) @(posedge pclk);
      chk(32'(mode), 32'(i == 0 ? MODE_RUN : MODE_FROZEN));
      chk(32'(digital_clk_en), 32'(i != 2));
      if (i != 0) begin
        chk(32'({sample_clk_en, convert_clk_en}), 32'h0);
      end
      acc(1'b0, OFS_CTRL_THREE, 32'h0);
      chk(q, 32'(sel[i]));
      background_debug_active <= 1'b0;
      waitm(MODE_RUN);
    end
    // Soft reset keeps power-up and results, clears control and status
    acc(1'b1, OFS_TEST, 32'h1);
    waitm(MODE_IDLE);
    acc(1'b0, OFS_CTRL_TWO, 32'h0);
    chk(q, 32'h1);
    acc(1'b0, OFS_CTRL_THREE, 32'h0);
    chk(q, 32'h0);
    acc(1'b0, OFS_STATUS, 32'h0);
    chk(q & 32'hFF, 32'h0);
    // System reset in mid-run
    acc(1'b1, OFS_SEQ_START, 32'h20);
    repeat (5) @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    acc(1'b0, OFS_CTRL_TWO, 32'h0);
    chk(q, 32'h0);
    chk(32'(mode), 32'(MODE_DOWN));
    chk(32'({sample_clk_en, convert_clk_en}), 32'h0);
    finish_test();
  end
endmodule : adc_power_mode_control_bench
